//--- frs_defs.svh
// constants of the floppy read command sequencer
// assumes inclusion by the package and the sequencer module
// Summary of operation
// - invalid opcode: no-op, standby, one result byte status_zero 80h
// - dump result reports sector_count after format, final sector after read/write
// - all transfer commands share parameter and result bytes; opcode bits 0-4 differ
// - implied seek enabled: seek to commanded cylinder before transfer
// - busy bit of addressed drive asserted during implied seek
// - failed seek: error code in status_zero, failing cylinder in result
// - load head, wait settle time, scan ID fields until sector matches
// - after each sector, increment sector number and read next sector
// - terminal count or overrun: stop data, finish sector, check CRC, end
// - sector size is 128 shifted left by size code, codes 0 to 7
// - size zero, short length below 128: send that many, read full sector
// - nonzero size code: short_transfer_length ignored
// - multitrack: run side 0 sector 1 through last sector of side 1
// - head stays loaded until unload interval expires after command
// - two index pulses without match: code 01, no_data_flag, end
// - CRC error: code 01, crc_error_flag; ID CRC sets second_reg_crc_flag
// - cylinder or sector advanced automatically except skip-rule cases
// - read data: deleted mark sets control mark; stop or skip by bypass bit
// - read deleted data: same with the roles of the two marks swapped
// - unchanged result values equal start values; at final sector report 01
`ifndef FRS_DEFS_SVH
`define FRS_DEFS_SVH
`define FRS_OP_READ      5'h06
`define FRS_OP_READ_DEL  5'h0c
`define FRS_OP_WRITE     5'h05
`define FRS_OP_WRITE_DEL 5'h09
`define FRS_OP_VERIFY    5'h16
`define FRS_OP_FORMAT    8'h4d
`define FRS_OP_DUMP      8'h0e
`define FRS_INVALID_ST0  8'h80
`define FRS_ABNORMAL     2'h1
`define FRS_CMD_BYTES    4'd9
`define FRS_DUMP_BYTES   4'd10
`define FRS_RES_BYTES    4'd7
`define FRS_BASE_SIZE    16'h0080
`define FRS_FIRST_SECTOR 8'h01
`define FRS_MS_UNIT_NS   1000000
`define FRS_CLK_NS       50
`endif

//--- frs_pkg.sv
// types of the floppy read command sequencer
// assumes frs_defs.svh is on the include path
`default_nettype none
`include "frs_defs.svh"
package frs_pkg;
  typedef struct packed {
    logic [7:0] cyl;
    logic [7:0] head;
    logic [7:0] sector;
    logic [7:0] size;
  } frs_addr_type;
  typedef struct packed {
    logic       valid;
    logic       deleted;
    logic       id_crc_bad;
    logic       data_crc_bad;
    frs_addr_type addr;
  } frs_sector_type;
  typedef enum logic [1:0] {FRS_LAST_NONE, FRS_LAST_RW, FRS_LAST_FMT} frs_last_type;
endpackage : frs_pkg
`default_nettype wire

//--- frs_sequencer.sv
// read-type data transfer command sequencer of a floppy controller
// assumes a byte-wide command/result port, a sector stream from the data separator,
// and drive positioning done by an outside seek engine
`timescale 1ns/100ps
`default_nettype none
`include "frs_defs.svh"
module frs_sequencer #(
  parameter int SETTLE_MS  = 16,
  parameter int UNLOAD_MS  = 240,
  parameter int SETTLE_CYC = SETTLE_MS * (`FRS_MS_UNIT_NS / `FRS_CLK_NS),
  parameter int UNLOAD_CYC = UNLOAD_MS * (`FRS_MS_UNIT_NS / `FRS_CLK_NS)
) (
  // clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  rst_in,
  // host command and result bytes
  input  wire logic                  cmd_valid_in,
  input  wire logic [7:0]            cmd_byte_in,
  output logic                       cmd_ready_out,
  output logic                       res_valid_out,
  output logic [7:0]                 res_byte_out,
  input  wire logic                  res_ack_in,
  input  wire logic                  terminal_count_in,
  input  wire logic                  implied_seek_en_in,
  output logic [3:0]                 drive_busy_out,
  output logic                       busy_out,
  // sector stream from the drive
  input  wire logic                  index_pulse_in,
  input  wire frs_pkg::frs_sector_type id_in,
  input  wire logic                  byte_valid_in,
  input  wire logic [7:0]            byte_in,
  input  wire logic                  sector_end_in,
  input  wire logic                  fifo_ready_in,
  output logic                       fifo_valid_out,
  output logic [7:0]                 fifo_data_out,
  output logic                       head_load_out,
  // seek engine
  output logic                       seek_req_out,
  output logic [7:0]                 seek_cyl_out,
  input  wire logic                  seek_done_in,
  input  wire logic                  seek_fail_in,
  input  wire logic [7:0]            seek_at_cyl_in
);
  import frs_pkg::*;
  typedef enum logic [2:0] {S_IDLE, S_CMD, S_SEEK, S_SETTLE, S_SCAN, S_DATA, S_RES}
    frs_state_type;
  frs_state_type state_reg;
  logic [7:0]   par_reg [0:8];
  logic [3:0]   cnt_reg;
  logic [3:0]   res_len_reg;
  frs_addr_type addr_reg;
  logic [7:0]   st0_reg;
  logic [7:0]   st1_reg;
  logic [7:0]   st2_reg;
  logic [1:0]   idx_reg;
  logic [15:0]  byte_cnt_reg;
  logic         tc_reg;
  logic         stop_reg;
  logic         skip_reg;
  logic [31:0]  timer_reg;
  logic [31:0]  unload_reg;
  frs_last_type last_reg;
  logic [7:0]   fifo_data_reg;
  logic         fifo_valid_reg;
  logic [7:0]   res_mux;
  logic [15:0]  xfer_len;
  logic         is_del_cmd;
  logic         mark_bad;
  logic         at_eot;
  logic         bypass;

  // low five opcode bits pick the transfer type; the upper bits are option flags
  function automatic logic is_transfer(input logic [7:0] b);
    return b[4:0] == `FRS_OP_READ || b[4:0] == `FRS_OP_READ_DEL ||
           b[4:0] == `FRS_OP_WRITE || b[4:0] == `FRS_OP_WRITE_DEL ||
           b[4:0] == `FRS_OP_VERIFY;
  endfunction : is_transfer

  assign is_del_cmd = par_reg[0][4:0] == `FRS_OP_READ_DEL;
  assign bypass     = par_reg[0][5];
  assign mark_bad   = id_in.deleted ^ is_del_cmd;
  assign xfer_len   = (par_reg[5] == 8'h00 && par_reg[8] < 8'h80) ? {8'h00, par_reg[8]}
                    : 16'(`FRS_BASE_SIZE << par_reg[5][2:0]);
  assign at_eot     = addr_reg.sector == par_reg[6];
  assign cmd_ready_out  = state_reg == S_IDLE || state_reg == S_CMD;
  assign res_valid_out  = state_reg == S_RES;
  assign busy_out       = state_reg != S_IDLE;
  assign fifo_valid_out = fifo_valid_reg;
  assign fifo_data_out  = fifo_data_reg;
  assign seek_req_out   = state_reg == S_SEEK;
  assign seek_cyl_out   = par_reg[2];
  assign head_load_out  = unload_reg != 32'h0 || (state_reg != S_IDLE && state_reg != S_RES
                          && state_reg != S_CMD);

  // busy bit of the addressed drive during the implied seek
  always_comb begin
    drive_busy_out = 4'h0;
    if (state_reg == S_SEEK) begin
      drive_busy_out[par_reg[1][1:0]] = 1'b1;
    end
  end

  always_comb begin
    case (cnt_reg)
      4'd0:    res_mux = st0_reg;
      4'd1:    res_mux = st1_reg;
      4'd2:    res_mux = st2_reg;
      4'd3:    res_mux = addr_reg.cyl;
      4'd4:    res_mux = addr_reg.head;
      4'd5:    res_mux = addr_reg.sector;
      4'd6:    res_mux = addr_reg.size;
      default: res_mux = 8'h00;
    endcase
    if (res_len_reg == `FRS_DUMP_BYTES) begin
      // sector count after format, final sector after read or write
      res_mux = (cnt_reg == 4'd6) ? ((last_reg == FRS_LAST_FMT) ? par_reg[7] : par_reg[6])
                                  : 8'h00;
    end
    res_byte_out = res_mux;
  end

  // head unload interval after a command
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      unload_reg <= 32'h0;
    end else if (state_reg == S_RES && res_len_reg == `FRS_RES_BYTES) begin
      // only a transfer result keeps the head loaded; invalid codes and dumps stay in standby
      unload_reg <= 32'(UNLOAD_CYC);
    end else if (unload_reg != 32'h0 && state_reg == S_IDLE) begin
      unload_reg <= unload_reg - 32'h1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg      <= S_IDLE;
      cnt_reg        <= 4'h0;
      res_len_reg    <= 4'h0;
      addr_reg       <= '0;
      st0_reg        <= 8'h00;
      st1_reg        <= 8'h00;
      st2_reg        <= 8'h00;
      idx_reg        <= 2'h0;
      byte_cnt_reg   <= 16'h0;
      tc_reg         <= 1'b0;
      stop_reg       <= 1'b0;
      skip_reg       <= 1'b0;
      timer_reg      <= 32'h0;
      last_reg       <= FRS_LAST_NONE;
      fifo_valid_reg <= 1'b0;
      fifo_data_reg  <= 8'h00;
      for (int i = 0; i < 9; i++) begin
        par_reg[i] <= 8'h00;
      end
    end else begin
      fifo_valid_reg <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (cmd_valid_in) begin
            par_reg[0] <= cmd_byte_in;
            cnt_reg    <= 4'h1;
            // a register dump answers from stored parameters without an execution phase
            if (cmd_byte_in == `FRS_OP_DUMP) begin
              cnt_reg     <= 4'h0;
              res_len_reg <= `FRS_DUMP_BYTES;
              state_reg   <= S_RES;
            end else if (is_transfer(cmd_byte_in)) begin
              state_reg <= S_CMD;
              if (cmd_byte_in[4:0] != `FRS_OP_VERIFY && cmd_byte_in[3:0] != 4'hd) begin
                last_reg <= FRS_LAST_RW;
              end
            end else begin
              if (cmd_byte_in == `FRS_OP_FORMAT) begin
                last_reg <= FRS_LAST_FMT;
              end
              st0_reg     <= `FRS_INVALID_ST0;
              cnt_reg     <= 4'h0;
              res_len_reg <= 4'h1;
              state_reg   <= S_RES;
            end
          end
        end
        S_CMD: begin
          if (cmd_valid_in) begin
            par_reg[cnt_reg] <= cmd_byte_in;
            cnt_reg          <= cnt_reg + 4'h1;
            // last parameter byte: seed the result registers from the command
            if (cnt_reg == `FRS_CMD_BYTES - 4'h1) begin
              st0_reg  <= {6'h00, par_reg[1][1:0]};
              st1_reg  <= 8'h00;
              st2_reg  <= 8'h00;
              addr_reg <= {par_reg[2], par_reg[3], par_reg[4], par_reg[5]};
              tc_reg   <= 1'b0;
              idx_reg  <= 2'h0;
              state_reg <= implied_seek_en_in ? S_SEEK : S_SETTLE;
              // settling is skipped while the head is still loaded from the last command
              timer_reg <= (unload_reg != 32'h0) ? 32'h0 : 32'(SETTLE_CYC);
            end
          end
        end
        S_SEEK: begin
          if (seek_fail_in) begin
            st0_reg[7:6]  <= `FRS_ABNORMAL;
            st0_reg[4]    <= 1'b1;
            addr_reg.cyl  <= seek_at_cyl_in;
            cnt_reg       <= 4'h0;
            res_len_reg   <= `FRS_RES_BYTES;
            state_reg     <= S_RES;
          end else if (seek_done_in) begin
            state_reg <= S_SETTLE;
          end
        end
        S_SETTLE: begin
          if (timer_reg == 32'h0) begin
            state_reg <= S_SCAN;
          end else begin
            timer_reg <= timer_reg - 32'h1;
          end
        end
        S_SCAN: begin
          if (index_pulse_in) begin
            idx_reg <= idx_reg + 2'h1;
          end
          // second index pulse without a matching ID ends the search
          if (index_pulse_in && idx_reg == 2'h1) begin
            st0_reg[7:6] <= `FRS_ABNORMAL;
            st1_reg[2]   <= 1'b1;
            cnt_reg      <= 4'h0;
            res_len_reg  <= `FRS_RES_BYTES;
            state_reg    <= S_RES;
          end else if (id_in.valid && id_in.id_crc_bad) begin
            st0_reg[7:6] <= `FRS_ABNORMAL;
            st1_reg[5]   <= 1'b1;
            st2_reg[5]   <= 1'b1;
            cnt_reg      <= 4'h0;
            res_len_reg  <= `FRS_RES_BYTES;
            state_reg    <= S_RES;
          end else if (id_in.valid && id_in.addr == addr_reg) begin
            idx_reg      <= 2'h0;
            byte_cnt_reg <= 16'h0;
            stop_reg     <= mark_bad && !bypass;
            skip_reg     <= mark_bad && bypass;
            if (mark_bad) begin
              st2_reg[6] <= 1'b1;
            end
            state_reg <= S_DATA;
          end
        end
        S_DATA: begin
          // a byte with no room in the fifo, unless the sector is skipped, is an overrun and acts as a terminal count
          if (terminal_count_in || (byte_valid_in && !fifo_ready_in && !skip_reg)) begin
            tc_reg <= 1'b1;
          end
          if (byte_valid_in) begin
            byte_cnt_reg <= byte_cnt_reg + 16'h1;
            if (!skip_reg && !tc_reg && !terminal_count_in && fifo_ready_in
                && byte_cnt_reg < xfer_len) begin
              fifo_valid_reg <= 1'b1;
              fifo_data_reg  <= byte_in;
            end
          end
          if (sector_end_in) begin
            cnt_reg     <= 4'h0;
            res_len_reg <= `FRS_RES_BYTES;
            if (id_in.data_crc_bad) begin
              st0_reg[7:6] <= `FRS_ABNORMAL;
              st1_reg[5]   <= 1'b1;
              state_reg    <= S_RES;
            end else if (stop_reg) begin
              state_reg <= S_RES; // address left as is
            end else if (at_eot && par_reg[0][7] && addr_reg.head[0] == 1'b0) begin
              addr_reg.head   <= addr_reg.head ^ 8'h01;
              addr_reg.sector <= `FRS_FIRST_SECTOR;
              state_reg       <= (tc_reg || terminal_count_in) ? S_RES : S_SCAN;
            end else if (at_eot) begin
              addr_reg.cyl    <= addr_reg.cyl + 8'h01;
              addr_reg.sector <= `FRS_FIRST_SECTOR;
              if (par_reg[0][7]) begin
                addr_reg.head <= addr_reg.head ^ 8'h01;
              end
              state_reg <= S_RES;
            end else begin
              addr_reg.sector <= addr_reg.sector + 8'h01;
              state_reg <= (tc_reg || terminal_count_in) ? S_RES : S_SCAN;
            end
          end
        end
        S_RES: begin
          if (res_ack_in) begin
            cnt_reg <= cnt_reg + 4'h1;
            if (cnt_reg == res_len_reg - 4'h1) begin
              state_reg <= S_IDLE;
            end
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule : frs_sequencer
`default_nettype wire

//--- frs_monitor.sv
// assertion checker for the read command sequencer ports
// assumes binding onto frs_sequencer and its hand-over timing
`timescale 1ns/100ps
`default_nettype none
module frs_monitor (
  // clock and reset
  input wire logic       clk_in,
  input wire logic       rst_in,
  // observed ports
  input wire logic       cmd_valid_in,
  input wire logic [7:0] cmd_byte_in,
  input wire logic       cmd_ready_out,
  input wire logic       res_valid_out,
  input wire logic [7:0] res_byte_out,
  input wire logic       res_ack_in,
  input wire logic       terminal_count_in,
  input wire logic [3:0] drive_busy_out,
  input wire logic       busy_out,
  input wire logic       byte_valid_in,
  input wire logic       fifo_valid_out,
  input wire logic       head_load_out,
  input wire logic       seek_req_out,
  input wire logic       seek_fail_in
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic tc_reg;
  // terminal count seen during the running command
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in) tc_reg <= 1'b0;
    else tc_reg <= busy_out && (tc_reg || terminal_count_in);
  sequence bad_op_s;
    cmd_valid_in && cmd_ready_out && !busy_out && cmd_byte_in[4:0] == 5'h1f;
  endsequence
  sequence noop_answer_s;
    res_valid_out && res_byte_out == 8'h80;
  endsequence
  sequence seek_err_s;
    res_valid_out && res_byte_out[7:6] == 2'h1 && res_byte_out[4];
  endsequence
  inv_result_a: assert property (bad_op_s |=> noop_answer_s)
    else $error("invalid opcode not answered with 80h");
  seek_busy_a: assert property (seek_req_out |-> $onehot(drive_busy_out))
    else $error("no single drive busy during seek");
  seek_fail_a: assert property (seek_req_out && seek_fail_in |-> ##[1:16] seek_err_s)
    else $error("failed seek not reported");
  result_hold_a: assert property (
    res_valid_out && !res_ack_in |=> res_valid_out && $stable(res_byte_out))
    else $error("result byte moved without ack");
  idle_return_a: assert property ($fell(res_valid_out) |-> cmd_ready_out && !busy_out)
    else $error("not idle after last result");
  fifo_cause_a: assert property (fifo_valid_out |-> $past(byte_valid_in))
    else $error("fifo byte without disk byte");
  tc_stop_a: assert property (tc_reg && $past(tc_reg) |-> !fifo_valid_out)
    else $error("data sent after terminal count");
  head_hold_a: assert property (
    $fell(busy_out) && $past(head_load_out) |-> head_load_out [*4])
    else $error("head unloaded too early");
endmodule : frs_monitor
bind frs_sequencer frs_monitor i_mon (.*);
`default_nettype wire

//--- frs_drive_model.sv
// drive and seek engine model facing the read command sequencer
// assumes one clock; ctl_in: [3:0] deleted sector, [4] id crc, [5] data crc,
// [6] seek fail, [7] size 1
`timescale 1ns/100ps
`default_nettype none
module frs_drive_model (
  input  wire logic               clk_in,
  input  wire logic               head_load_in,
  input  wire logic [7:0]         ctl_in,
  output logic                    index_pulse_out,
  output frs_pkg::frs_sector_type id_out,
  output logic                    byte_valid_out,
  output logic [7:0]              byte_out,
  output logic                    sector_end_out,
  input  wire logic               seek_req_in,
  input  wire logic [7:0]         seek_cyl_in,
  output logic                    seek_done_out,
  output logic                    seek_fail_out,
  output logic [7:0]              seek_at_cyl_out
);
  import frs_pkg::*;
  logic [7:0] cyl_reg = 8'h00;
  // one revolution: sectors 1..4, each on side 0 then side 1
  initial begin
    {index_pulse_out, id_out, byte_valid_out, byte_out, sector_end_out} = '0;
    forever begin
      @(posedge clk_in);
      if (head_load_in) begin
        index_pulse_out <= 1'b1;
        @(posedge clk_in) index_pulse_out <= 1'b0;
        for (int s = 1; s <= 4; s++) for (int h = 0; h < 2; h++) begin
          repeat (4) @(posedge clk_in);
          id_out <= {1'b1, ctl_in[3:0] == s[3:0], ctl_in[4] && s == 1, ctl_in[5] && s == 1,
                     cyl_reg, h[7:0], s[7:0], 7'h00, ctl_in[7]};
          @(posedge clk_in) id_out.valid <= 1'b0;
          for (int i = 0; i < (128 << ctl_in[7]); i++) begin
            @(posedge clk_in) {byte_valid_out, byte_out} <= {1'b1, s[7:0] + i[7:0]};
            @(posedge clk_in) {byte_valid_out, byte_out} <= {1'b0, ~byte_out};
          end
          @(posedge clk_in) sector_end_out <= 1'b1;
          @(posedge clk_in) sector_end_out <= 1'b0;
        end
      end
    end
  end
  // seek engine: answers three cycles after a request
  initial begin
    {seek_done_out, seek_fail_out, seek_at_cyl_out} = '0;
    forever begin
      @(posedge clk_in);
      if (seek_req_in) begin
        repeat (3) @(posedge clk_in);
        if (ctl_in[6]) {seek_fail_out, seek_at_cyl_out} <= {1'b1, 8'h03};
        else {seek_done_out, cyl_reg} <= {1'b1, seek_cyl_in};
        @(posedge clk_in) {seek_done_out, seek_fail_out} <= 2'b00;
        repeat (2) @(posedge clk_in);
      end
    end
  end
endmodule : frs_drive_model
`default_nettype wire

//--- testbench.sv
// self-checking bench of the read command sequencer with a drive model
// assumes frs_pkg, the sequencer, its checker and the drive model are compiled
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import frs_pkg::*;
  typedef struct packed {
    logic [71:0] cmd;
    logic [7:0]  ctl;
    logic        seek;
    logic [15:0] nb;
    logic [55:0] res;
  } frs_row_type;
  logic           clk_in = 1'b0, rst_in = 1'b1, cmd_valid_in = 1'b0, res_ack_in = 1'b0;
  logic           terminal_count_in = 1'b0, implied_seek_en_in = 1'b0, fifo_ready_in = 1'b1;
  logic [7:0]     cmd_byte_in = 8'h00, ctl = 8'h00, res_byte_out, fifo_data_out, byte_in;
  logic [7:0]     seek_cyl_out, seek_at_cyl_in;
  logic           cmd_ready_out, res_valid_out, busy_out, fifo_valid_out, head_load_out;
  logic           index_pulse_in, byte_valid_in, sector_end_in, seek_req_out;
  logic           seek_done_in, seek_fail_in;
  logic [3:0]     drive_busy_out;
  frs_sector_type id_in;
  logic [15:0]    nb_seen = 16'h0000;
  logic [7:0]     first_byte = 8'h00;
  logic [79:0]    r;
  int             n_fail = 0, samples_checked = 0;
  frs_row_type rows [13] = '{
    '{72'h06_00_00_00_01_00_02_1b_ff, 8'h00, 1'b0, 16'd256, 56'h00_00_00_01_00_01_00},
    '{72'h06_00_00_00_01_00_01_1b_10, 8'h00, 1'b0, 16'd16, 56'h00_00_00_01_00_01_00},
    '{72'h06_00_00_00_01_01_01_1b_10, 8'h80, 1'b0, 16'd256, 56'h00_00_00_01_00_01_01},
    '{72'h26_00_00_00_01_00_02_1b_ff, 8'h01, 1'b0, 16'd128, 56'h00_00_40_01_00_01_00},
    '{72'h06_00_00_00_01_00_02_1b_ff, 8'h01, 1'b0, 16'd128, 56'h00_00_40_00_00_01_00},
    '{72'h0c_00_00_00_01_00_02_1b_ff, 8'h00, 1'b0, 16'd128, 56'h00_00_40_00_00_01_00},
    '{72'h2c_00_00_00_01_00_02_1b_ff, 8'h02, 1'b0, 16'd128, 56'h00_00_40_01_00_01_00},
    '{72'h86_00_00_00_01_00_01_1b_ff, 8'h00, 1'b0, 16'd256, 56'h00_00_00_01_00_01_00},
    '{72'h06_00_00_00_09_00_09_1b_ff, 8'h00, 1'b0, 16'd0, 56'h40_04_00_00_00_09_00},
    '{72'h06_00_00_00_01_00_02_1b_ff, 8'h10, 1'b0, 16'd0, 56'h40_20_20_00_00_01_00},
    '{72'h06_00_00_00_01_00_02_1b_ff, 8'h20, 1'b0, 16'd128, 56'h40_20_00_00_00_01_00},
    '{72'h06_00_05_00_01_00_01_1b_ff, 8'h00, 1'b1, 16'd128, 56'h00_00_00_06_00_01_00},
    '{72'h06_00_07_00_01_00_03_1b_ff, 8'h40, 1'b1, 16'd0, 56'h50_00_00_03_00_01_00}};
  frs_sequencer #(.SETTLE_CYC(4), .UNLOAD_CYC(8)) i_dut (.*);
  frs_drive_model i_drive (
    .clk_in(clk_in), .head_load_in(head_load_out), .ctl_in(ctl),
    .index_pulse_out(index_pulse_in), .id_out(id_in), .byte_valid_out(byte_valid_in),
    .byte_out(byte_in), .sector_end_out(sector_end_in), .seek_req_in(seek_req_out),
    .seek_cyl_in(seek_cyl_out), .seek_done_out(seek_done_in),
    .seek_fail_out(seek_fail_in), .seek_at_cyl_out(seek_at_cyl_in));
  initial forever #25 clk_in = ~clk_in;
  always @(negedge clk_in) if (fifo_valid_out === 1'b1) begin
    nb_seen <= nb_seen + 16'd1;
    if (nb_seen == 16'd0) first_byte <= fifo_data_out;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  // send the first n command bytes of c, each held until cmd_ready_out is seen high
  task automatic send(input logic [71:0] c, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge clk_in) {cmd_valid_in, cmd_byte_in} <= {1'b1, c[71 - 8 * i -: 8]};
      while (cmd_ready_out !== 1'b1) @(negedge clk_in);
    end
    @(negedge clk_in) cmd_valid_in <= 1'b0;
  endtask : send
  task automatic getres(input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge clk_in);
      while (res_valid_out !== 1'b1) @(negedge clk_in);
      r[79 - 8 * i -: 8] = res_byte_out;
      res_ack_in <= 1'b1;
      @(negedge clk_in) res_ack_in <= 1'b0;
    end
  endtask : getres
  task automatic print_verdict;
    $display("checked %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  initial begin
    #4500000;
    n_fail++;
    print_verdict();
  end
  initial begin
    repeat (16) @(posedge clk_in);
    @(negedge clk_in) rst_in <= 1'b0;
    chk(16'({cmd_ready_out, res_valid_out, busy_out, head_load_out}), 16'h0008);
    send({8'h1f, 64'h0}, 1);
    getres(1);
    chk(16'(r[79:72]), 16'h0080);
    @(negedge clk_in) chk(16'({cmd_ready_out, busy_out}), 16'h0002);
    $display("invalid opcode test done");
    foreach (rows[k]) begin
      {ctl, implied_seek_en_in, nb_seen} = {rows[k].ctl, rows[k].seek, 16'd0};
      send(rows[k].cmd, 9);
      getres(7);
      for (int j = 0; j < 7; j++)
        if (j != 4 || !rows[k].cmd[71])
          chk(16'(r[79 - 8 * j -: 8]), 16'(rows[k].res[55 - 8 * j -: 8]));
      chk(nb_seen, rows[k].nb);
      $display("row %0d done", k);
    end
    {ctl, implied_seek_en_in, nb_seen} = 25'd0;
    fork
      send(72'h06_00_05_00_01_00_03_1b_ff, 9);
      begin
        while (nb_seen < 16'd10) @(negedge clk_in);
        terminal_count_in = 1'b1;
      end
    join
    getres(7);
    terminal_count_in = 1'b0;
    chk(16'({r[55:48], r[39:32]}), 16'h0502);
    chk(16'(nb_seen inside {[10:11]}), 16'h0001);
    chk(16'(first_byte), 16'h0001);
    $display("terminal count test done");
    {fifo_ready_in, nb_seen} = 17'd0;
    send(72'h06_00_05_00_01_00_03_1b_ff, 9);
    getres(7);
    fifo_ready_in = 1'b1;
    chk(16'({r[55:48], r[39:32]}), 16'h0502);
    chk(nb_seen, 16'h0000);
    $display("fifo overrun test done");
    repeat (20) @(negedge clk_in);
    send({8'h0e, 64'h0}, 1);
    getres(10);
    chk(16'(r[31:24]), 16'h0003);
    $display("dump test done");
    fork send(72'h06_00_05_00_01_00_03_1b_ff, 9); join_none
    repeat (40) @(negedge clk_in);
    rst_in = 1'b1;
    @(negedge clk_in);
    chk(16'({cmd_ready_out, res_valid_out, busy_out, head_load_out}), 16'h0008);
    rst_in = 1'b0;
    send({8'h1f, 64'h0}, 1);
    getres(1);
    chk(16'(r[79:72]), 16'h0080);
    $display("mid-command reset test done");
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
